/* hdl/config_decode.sv */
// Decoder from the latched configuration word to option outputs
`timescale 1ns/1ps
`default_nettype none
module config_decode (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [prom_pkg::DATA_W-1:0] i_cfg,
  input wire prom_pkg::cpu_mode_e i_cpu_mode,
  input wire logic i_pin_level,
  output prom_pkg::cfg_out_s o_cfg,
  output logic o_ext_reset_req,
  output logic o_pin_gpio_in
);
  typedef struct packed {
    prom_pkg::cfg_out_s cfg;
    logic ext_reset_req;
    logic pin_gpio_in;
  } dec_s;
  dec_s st;
  dec_s next_st;
  logic [1:0] wdt_code;

  // Pure decode of the stable word, registered for clean outputs
  always_comb begin
    wdt_code = i_cfg[prom_pkg::WDT_MSB:prom_pkg::WDT_LSB];
    next_st = st;
    next_st.cfg.wdt_enable = wdt_code[1] & (wdt_code[0] |
      i_cpu_mode == prom_pkg::MODE_FAST |
      i_cpu_mode == prom_pkg::MODE_SLOW);
    next_st.cfg.lvr_level = i_cfg[prom_pkg::LVR_MSB:prom_pkg::LVR_LSB];
    next_st.cfg.xrst_enable = i_cfg[prom_pkg::XRST_BIT];
    next_st.cfg.osc_div2 = i_cfg[prom_pkg::PSC_BIT];
    next_st.cfg.por_duty = i_cfg[prom_pkg::POR_BIT];
    // Pin is reset when enabled (active low), else plain I/O
    next_st.ext_reset_req = i_cfg[prom_pkg::XRST_BIT] & ~i_pin_level;
    next_st.pin_gpio_in = i_cfg[prom_pkg::XRST_BIT] ? 1'b0 : i_pin_level;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_cfg = st.cfg;
  assign o_ext_reset_req = st.ext_reset_req;
  assign o_pin_gpio_in = st.pin_gpio_in;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  a_wdt_idle_off: assert property (
    (i_cpu_mode == prom_pkg::MODE_IDLE && !i_cfg[prom_pkg::WDT_LSB])
    |=> !o_cfg.wdt_enable)
    else $error("watchdog enabled in idle with code 10");
  a_wdt_always: assert property (
    (i_cfg[prom_pkg::WDT_MSB:prom_pkg::WDT_LSB] == 2'h3) |=> o_cfg.wdt_enable)
    else $error("watchdog not enabled with code 11");
endmodule : config_decode
`default_nettype wire

/* hdl/program_rom_and_config_word.sv */
// Program ROM access, code lock, read delay and boot configuration
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Code store of 4K words (2K option) plus 32-word info area.
// - Programmer reads user code only while the lock bit 15 is clear.
// - Programmer may read the configuration word whatever the lock.
// - Lock bit clears only after the user code area was erased.
// - While locked, user code writes are refused.
// - Register 113h bits 1..0 pick read strobe delay 20/16/12/8 ns.
// - Any reset sets the program counter to 000h and registers default.
// - Taken interrupt pushes the program counter and jumps to 004h.
// - Configuration word is 16 bits, changed only by programming.
// - Bits 13-12 decode watchdog enable: off, run-modes only, always.
// - Bits 11-8 select one of sixteen low-voltage reset thresholds.
// - Bit 7 makes the shared pin a reset input instead of I/O.
// - Bit 5 divides the fast oscillator by two, 16 to 8 MHz.
// - Bit 4 runs the power-on detector at 1/16 duty.
module program_rom_and_config_word #(
  parameter int CODE_WORDS = prom_pkg::CODE_WORDS_DEF,
  parameter int INFO_WORDS = prom_pkg::INFO_WORDS_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_por_n,
  input wire logic [prom_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic [prom_pkg::REG_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [prom_pkg::REG_DW-1:0] o_reg_rdata,
  input wire logic i_fetch_req,
  output logic o_fetch_valid,
  output logic [prom_pkg::DATA_W-1:0] o_fetch_data,
  input wire logic i_pc_step,
  input wire logic i_jump,
  input wire logic [prom_pkg::CODE_AW-1:0] i_jump_addr,
  input wire logic i_irq_take,
  input wire logic i_ret,
  output logic [prom_pkg::CODE_AW-1:0] o_pc,
  output logic o_cpu_run,
  input wire logic i_prog_valid,
  input wire prom_pkg::prog_req_s i_prog_req,
  output logic [prom_pkg::DATA_W-1:0] o_prog_rdata,
  output logic o_prog_done,
  output logic o_prog_refused,
  input wire prom_pkg::cpu_mode_e i_cpu_mode,
  input wire logic i_shared_pin,
  output prom_pkg::cfg_out_s o_cfg,
  output logic o_ext_reset_req,
  output logic o_pin_gpio_in,
  output logic [prom_pkg::DATA_W-1:0] o_config_word
);
  typedef struct packed {
    prom_pkg::boot_e boot;
    logic [prom_pkg::DATA_W-1:0] cfg;
    logic [1:0] rd_delay;
    logic [prom_pkg::REG_DW-1:0] reg_rdata;
    logic [prom_pkg::CODE_AW-1:0] pc;
    logic [prom_pkg::STACK_DEPTH-1:0][prom_pkg::CODE_AW-1:0] stack;
    logic [prom_pkg::SP_W-1:0] sp;
    logic [prom_pkg::CNT_W-1:0] fetch_cnt;
    logic [prom_pkg::CODE_AW-1:0] fetch_addr;
    logic fetch_valid;
    logic [prom_pkg::DATA_W-1:0] fetch_data;
    logic vld1;
    logic vld2;
    logic vld3;
    prom_pkg::prog_req_s req1;
    prom_pkg::prog_req_s req2;
    prom_pkg::prog_req_s prog;
    logic prog_busy;
    logic prog_phase;
    logic [prom_pkg::DATA_W-1:0] prog_rdata;
    logic prog_done;
    logic prog_refused;
    logic pin1;
    logic pin2;
  } state_s;

  state_s st;
  state_s next_st;
  logic run;
  logic lock;
  logic fetch_take;
  logic code_we;
  logic code_erase;
  logic info_we;
  logic [prom_pkg::DATA_W-1:0] info_wdata;
  logic [prom_pkg::CODE_AW-1:0] code_addr;
  logic [prom_pkg::CNT_W-1:0] delay_cyc;
  logic [prom_pkg::DATA_W-1:0] code_rdata;
  logic [prom_pkg::DATA_W-1:0] info_rdata;
  logic [prom_pkg::DATA_W-1:0] info_word0;
  logic code_erased;

  prom_array #(
    .CODE_WORDS(CODE_WORDS),
    .INFO_WORDS(INFO_WORDS)
  ) u_array (
    .i_ref_clk(i_ref_clk),
    .i_por_n(i_por_n),
    .i_code_we(code_we),
    .i_code_erase(code_erase),
    .i_code_addr(code_addr),
    .i_code_wdata(st.prog.wdata),
    .i_info_we(info_we),
    .i_info_addr(st.prog.addr[prom_pkg::INFO_AW-1:0]),
    .i_info_wdata(info_wdata),
    .o_code_rdata(code_rdata),
    .o_info_rdata(info_rdata),
    .o_info_word0(info_word0),
    .o_code_erased(code_erased)
  );

  config_decode u_decode (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_cfg(st.cfg),
    .i_cpu_mode(i_cpu_mode),
    .i_pin_level(st.pin2),
    .o_cfg(o_cfg),
    .o_ext_reset_req(o_ext_reset_req),
    .o_pin_gpio_in(o_pin_gpio_in)
  );

  // Strobe delay in cycles, one less since data lands the cycle after
  always_comb begin
    unique case (st.rd_delay)
      2'h0: delay_cyc = prom_pkg::CNT_W'(prom_pkg::DELAY_00_CYC - 1);
      2'h1: delay_cyc = prom_pkg::CNT_W'(prom_pkg::DELAY_01_CYC - 1);
      2'h2: delay_cyc = prom_pkg::CNT_W'(prom_pkg::DELAY_10_CYC - 1);
      2'h3: delay_cyc = prom_pkg::CNT_W'(prom_pkg::DELAY_11_CYC - 1);
    endcase
  end

  // Lock is taken live from the stored word, so it acts at once
  assign lock = info_word0[prom_pkg::LOCK_BIT];
  assign run = (st.boot == prom_pkg::BOOT_RUN);
  assign fetch_take = run && i_fetch_req && st.fetch_cnt == '0;

  // Single code read port: new fetch, held fetch, then programmer
  always_comb begin
    if (fetch_take) begin
      code_addr = st.pc;
    end else if (st.fetch_cnt != '0) begin
      code_addr = st.fetch_addr;
    end else begin
      code_addr = st.prog.addr;
    end
  end

  // Whole next-state function
  always_comb begin
    next_st = st;
    code_we = 1'b0;
    code_erase = 1'b0;
    info_we = 1'b0;
    info_wdata = st.prog.wdata;
    next_st.fetch_valid = 1'b0;
    next_st.prog_done = 1'b0;
    next_st.prog_refused = 1'b0;
    next_st.reg_rdata = '0;

    // Programmer pins and shared pin come from outside: two stages
    next_st.vld1 = i_prog_valid;
    next_st.vld2 = st.vld1;
    next_st.vld3 = st.vld2;
    next_st.req1 = i_prog_req;
    next_st.req2 = st.req1;
    next_st.pin1 = i_shared_pin;
    next_st.pin2 = st.pin1;

    // Register port; config word is read only from software
    if (i_reg_wr && i_reg_addr == prom_pkg::RD_DELAY_OFFSET) begin
      next_st.rd_delay = i_reg_wdata[prom_pkg::RD_DELAY_MSB:
                                     prom_pkg::RD_DELAY_LSB];
    end
    if (i_reg_rd) begin
      if (i_reg_addr == prom_pkg::RD_DELAY_OFFSET) begin
        next_st.reg_rdata = {6'h00, st.rd_delay};
      end else if (i_reg_addr == prom_pkg::CFG_LOW_OFFSET) begin
        next_st.reg_rdata = st.cfg[7:0];
      end else if (i_reg_addr == prom_pkg::CFG_HIGH_OFFSET) begin
        next_st.reg_rdata = st.cfg[15:8];
      end
    end

    // Boot: latch the word before any fetch is accepted
    unique case (st.boot)
      prom_pkg::BOOT_LOAD: begin
        next_st.cfg = info_word0;
        next_st.boot = prom_pkg::BOOT_RUN;
      end
      prom_pkg::BOOT_RUN: begin
      end
    endcase

    // Program counter; the stack wraps silently when overfilled
    if (run) begin
      if (i_irq_take) begin
        next_st.stack[st.sp] = st.pc;
        next_st.sp = st.sp + 1'b1;
        next_st.pc = prom_pkg::IRQ_VECTOR;
      end else if (i_ret) begin
        next_st.sp = st.sp - 1'b1;
        next_st.pc = st.stack[st.sp - 1'b1];
      end else if (i_jump) begin
        next_st.pc = i_jump_addr;
      end else if (i_pc_step) begin
        next_st.pc = st.pc + 1'b1;
      end
    end

    // Fetch answered after the selected strobe delay
    if (fetch_take) begin
      next_st.fetch_cnt = delay_cyc;
      next_st.fetch_addr = st.pc;
    end else if (st.fetch_cnt != '0) begin
      next_st.fetch_cnt = st.fetch_cnt - 1'b1;
      if (st.fetch_cnt == 3'h1) begin
        next_st.fetch_valid = 1'b1;
        next_st.fetch_data = code_rdata;
      end
    end

    // Programmer: one command per rising edge of its valid
    if (!st.prog_busy) begin
      if (st.vld2 && !st.vld3) begin
        next_st.prog = st.req2;
        next_st.prog_busy = 1'b1;
        next_st.prog_phase = 1'b0;
      end
    end else begin
      unique case (st.prog.cmd)
        prom_pkg::PROG_READ_CODE: begin
          if (lock) begin
            next_st.prog_rdata = '0;
            next_st.prog_refused = 1'b1;
            next_st.prog_busy = 1'b0;
          end else if (!st.prog_phase) begin
            // Wait until the fetch path leaves the port free
            if (st.fetch_cnt == '0 && !fetch_take) begin
              next_st.prog_phase = 1'b1;
            end
          end else begin
            next_st.prog_rdata = code_rdata;
            next_st.prog_done = 1'b1;
            next_st.prog_busy = 1'b0;
          end
        end
        prom_pkg::PROG_WRITE_CODE: begin
          if (lock) begin
            next_st.prog_refused = 1'b1;
          end else if (st.fetch_cnt == '0 && !fetch_take) begin
            code_we = 1'b1;
            next_st.prog_done = 1'b1;
          end
          // A refused write ends at once; only a busy fetch port holds it
          next_st.prog_busy = !lock && ((st.fetch_cnt != '0) || fetch_take);
        end
        prom_pkg::PROG_ERASE_CODE: begin
          code_erase = 1'b1;
          next_st.prog_done = 1'b1;
          next_st.prog_busy = 1'b0;
        end
        prom_pkg::PROG_READ_INFO: begin
          next_st.prog_rdata = info_rdata;
          next_st.prog_done = 1'b1;
          next_st.prog_busy = 1'b0;
        end
        prom_pkg::PROG_WRITE_INFO: begin
          // Keep the lock set unless the code area is blank
          if (st.prog.addr[prom_pkg::INFO_AW-1:0] == '0 && lock &&
              !code_erased) begin
            info_wdata[prom_pkg::LOCK_BIT] = 1'b1;
            next_st.prog_refused = !st.prog.wdata[prom_pkg::LOCK_BIT];
          end
          info_we = 1'b1;
          next_st.prog_done = 1'b1;
          next_st.prog_busy = 1'b0;
        end
        default: begin
          next_st.prog_refused = 1'b1;
          next_st.prog_busy = 1'b0;
        end
      endcase
    end
  end

  // Every reset restarts boot at the reset vector
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
      st.boot <= prom_pkg::BOOT_LOAD;
      st.pc <= prom_pkg::RESET_VECTOR;
      st.rd_delay <= prom_pkg::RD_DELAY_RESET;
      st.cfg <= prom_pkg::CONFIG_DEFAULT;
    end else begin
      st <= next_st;
    end
  end

  assign o_reg_rdata = st.reg_rdata;
  assign o_fetch_valid = st.fetch_valid;
  assign o_fetch_data = st.fetch_data;
  assign o_pc = st.pc;
  assign o_cpu_run = run;
  assign o_prog_rdata = st.prog_rdata;
  assign o_prog_done = st.prog_done;
  assign o_prog_refused = st.prog_refused;
  assign o_config_word = st.cfg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  a_boot_vector: assert property ($rose(o_cpu_run) |-> o_pc == 12'h000)
    else $error("run begins away from reset vector");
  a_irq_jump: assert property (
    (run && i_irq_take) |=> (o_pc == 12'h004 && st.sp == $past(st.sp) + 3'h1))
    else $error("interrupt did not push and jump to 004h");
  a_irq_push: assert property (
    (run && i_irq_take) |=> st.stack[$past(st.sp)] == $past(st.pc))
    else $error("pushed counter lost");
  a_lock_read: assert property (
    (st.prog_busy && st.prog.cmd == prom_pkg::PROG_READ_CODE && lock)
    |=> (o_prog_refused && !o_prog_done && o_prog_rdata == 16'h0000))
    else $error("locked code read not blocked");
  a_info_read: assert property (
    (st.prog_busy && st.prog.cmd == prom_pkg::PROG_READ_INFO)
    |=> (o_prog_done && !o_prog_refused && o_prog_rdata == $past(info_rdata)))
    else $error("info read not served");
  a_lock_write: assert property (code_we |-> !lock)
    else $error("code written while locked");
  a_unlock_guard: assert property (
    (info_we && st.prog.addr[4:0] == 5'h00 && lock && !code_erased)
    |=> lock)
    else $error("lock cleared before erase");
  a_delay_slow: assert property (
    (fetch_take && st.rd_delay == 2'h0)
    |=> !o_fetch_valid [*4] ##1 o_fetch_valid)
    else $error("20 ns fetch not five cycles");
  a_delay_fast: assert property (
    (fetch_take && st.rd_delay == 2'h3) |=> !o_fetch_valid ##1 o_fetch_valid)
    else $error("8 ns fetch not two cycles");
  a_cfg_stable: assert property (
    (run && $past(run)) |-> $stable(o_config_word))
    else $error("configuration word changed while running");
  a_reg_read: assert property (
    (i_reg_rd && i_reg_addr == 9'h113)
    |=> o_reg_rdata == {6'h00, $past(st.rd_delay)})
    else $error("delay field read back wrong");

  c_locked_read: cover property (st.prog_busy && lock &&
    st.prog.cmd == prom_pkg::PROG_READ_CODE);
  c_irq_taken: cover property (run && i_irq_take);
  c_fast_fetch: cover property (fetch_take && st.rd_delay == 2'h3);
  c_unlock_after_erase: cover property (info_we && lock && code_erased);
endmodule : program_rom_and_config_word
`default_nettype wire

/* hdl/prom_array.sv */
// Rewritable code store and information area storage
`timescale 1ns/1ps
`default_nettype none
module prom_array #(
  parameter int CODE_WORDS = prom_pkg::CODE_WORDS_DEF,
  parameter int INFO_WORDS = prom_pkg::INFO_WORDS_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_por_n,
  input wire logic i_code_we,
  input wire logic i_code_erase,
  input wire logic [prom_pkg::CODE_AW-1:0] i_code_addr,
  input wire logic [prom_pkg::DATA_W-1:0] i_code_wdata,
  input wire logic i_info_we,
  input wire logic [prom_pkg::INFO_AW-1:0] i_info_addr,
  input wire logic [prom_pkg::DATA_W-1:0] i_info_wdata,
  output logic [prom_pkg::DATA_W-1:0] o_code_rdata,
  output logic [prom_pkg::DATA_W-1:0] o_info_rdata,
  output logic [prom_pkg::DATA_W-1:0] o_info_word0,
  output logic o_code_erased
);
  localparam int AW = $clog2(CODE_WORDS);
  typedef struct packed {
    logic erased;
    logic info_blank;
  } flags_s;

  // Code words plus the separate info area
  logic [prom_pkg::DATA_W-1:0] code_mem [CODE_WORDS];
  logic [prom_pkg::DATA_W-1:0] info_mem [INFO_WORDS];
  flags_s fl;
  flags_s next_fl;

  // Erase and write bookkeeping; only power-on clears it
  always_comb begin
    next_fl = fl;
    if (i_code_erase) begin
      next_fl.erased = 1'b1;
    end else if (i_code_we) begin
      next_fl.erased = 1'b0;
    end
    if (i_info_we && i_info_addr == '0) begin
      next_fl.info_blank = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      fl <= '{erased: 1'b1, info_blank: 1'b1};
    end else begin
      fl <= next_fl;
    end
  end

  // Storage has no reset, like the real cells; erase sets every code word
  always_ff @(posedge i_ref_clk) begin
    if (i_code_erase) begin
      for (int i = 0; i < CODE_WORDS; i++) begin
        code_mem[i] <= prom_pkg::ERASED_WORD;
      end
    end else if (i_code_we) begin
      code_mem[i_code_addr[AW-1:0]] <= i_code_wdata;
    end
    if (i_info_we) begin
      info_mem[i_info_addr] <= i_info_wdata;
    end
    o_code_rdata <= code_mem[i_code_addr[AW-1:0]];
  end

  // Blank info word 0 reads as the factory word
  assign o_info_word0 = fl.info_blank ? prom_pkg::CONFIG_DEFAULT : info_mem[0];
  assign o_info_rdata = (i_info_addr == '0) ? o_info_word0 :
                        info_mem[i_info_addr];
  assign o_code_erased = fl.erased;
endmodule : prom_array
`default_nettype wire

/* pkg/prom_pkg.sv */
// Shared constants and carrier types for program ROM and configuration word
package prom_pkg;
  localparam int DATA_W = 16;
  localparam int CODE_AW = 12;
  localparam int INFO_AW = 5;
  localparam int REG_AW = 9;
  localparam int REG_DW = 8;
  localparam int CODE_WORDS_DEF = 4096;
  localparam int INFO_WORDS_DEF = 32;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int CNT_W = 3;

  // Register offsets on the plain register port
  localparam logic [REG_AW-1:0] RD_DELAY_OFFSET = 9'h113;
  localparam logic [REG_AW-1:0] CFG_LOW_OFFSET = 9'h1fe;
  localparam logic [REG_AW-1:0] CFG_HIGH_OFFSET = 9'h1ff;
  localparam logic [1:0] RD_DELAY_RESET = 2'h0;
  localparam int RD_DELAY_LSB = 0;
  localparam int RD_DELAY_MSB = 1;

  // Configuration word layout
  localparam logic [DATA_W-1:0] CONFIG_DEFAULT = 16'h0200;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
  localparam int LOCK_BIT = 15;
  localparam int WDT_MSB = 13;
  localparam int WDT_LSB = 12;
  localparam int LVR_MSB = 11;
  localparam int LVR_LSB = 8;
  localparam int XRST_BIT = 7;
  localparam int PSC_BIT = 5;
  localparam int POR_BIT = 4;

  // Vectors
  localparam logic [CODE_AW-1:0] RESET_VECTOR = 12'h000;
  localparam logic [CODE_AW-1:0] IRQ_VECTOR = 12'h004;

  // Read strobe delay: figures in ns, counts rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 4;
  localparam int DELAY_00_NS = 20;
  localparam int DELAY_01_NS = 16;
  localparam int DELAY_10_NS = 12;
  localparam int DELAY_11_NS = 8;
  localparam int DELAY_00_CYC = (DELAY_00_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_01_CYC = (DELAY_01_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_10_CYC = (DELAY_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_11_CYC = (DELAY_11_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PROG_READ_CODE = 3'h0,
    PROG_WRITE_CODE = 3'h1,
    PROG_ERASE_CODE = 3'h2,
    PROG_READ_INFO = 3'h3,
    PROG_WRITE_INFO = 3'h4
  } prog_cmd_e;

  typedef enum logic [1:0] {
    MODE_FAST = 2'h0,
    MODE_SLOW = 2'h1,
    MODE_IDLE = 2'h2,
    MODE_STOP = 2'h3
  } cpu_mode_e;

  typedef enum logic {
    BOOT_LOAD = 1'b0,
    BOOT_RUN = 1'b1
  } boot_e;

  typedef struct packed {
    prog_cmd_e cmd;
    logic [CODE_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } prog_req_s;

  typedef struct packed {
    logic wdt_enable;
    logic [3:0] lvr_level;
    logic xrst_enable;
    logic osc_div2;
    logic por_duty;
  } cfg_out_s;
endpackage : prom_pkg

/* sim/program_rom_and_config_word_bench.sv */
// Self-checking bench for program ROM access and configuration word
`timescale 1ns/1ps
`default_nettype none
module program_rom_and_config_word_bench;
  logic i_ref_clk, i_reset_n, i_por_n, i_reg_wr, i_reg_rd, i_fetch_req;
  logic i_jump, i_irq_take, i_ret, i_shared_pin, i_prog_valid, i_pc_step;
  logic o_fetch_valid, o_cpu_run, o_prog_done, o_prog_refused;
  logic o_ext_reset_req, o_pin_gpio_in;
  logic [8:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, rd;
  logic [11:0] i_jump_addr, o_pc;
  logic [15:0] o_fetch_data, o_prog_rdata, o_config_word;
  prom_pkg::prog_req_s i_prog_req;
  prom_pkg::cpu_mode_e i_cpu_mode;
  prom_pkg::cfg_out_s o_cfg;
  int num_errors = 0;
  int n_checks = 0;
  int n;
  int lat[4] = '{prom_pkg::DELAY_00_CYC, prom_pkg::DELAY_01_CYC,
                 prom_pkg::DELAY_10_CYC, prom_pkg::DELAY_11_CYC};
  program_rom_and_config_word u_program_rom_and_config_word (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_por_n(i_por_n),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_fetch_req(i_fetch_req), .o_fetch_valid(o_fetch_valid),
    .o_fetch_data(o_fetch_data), .i_pc_step(i_pc_step), .i_jump(i_jump),
    .i_jump_addr(i_jump_addr), .i_irq_take(i_irq_take), .i_ret(i_ret),
    .o_pc(o_pc), .o_cpu_run(o_cpu_run), .i_prog_valid(i_prog_valid),
    .i_prog_req(i_prog_req), .o_prog_rdata(o_prog_rdata),
    .o_prog_done(o_prog_done), .o_prog_refused(o_prog_refused),
    .i_cpu_mode(i_cpu_mode), .i_shared_pin(i_shared_pin), .o_cfg(o_cfg),
    .o_ext_reset_req(o_ext_reset_req), .o_pin_gpio_in(o_pin_gpio_in),
    .o_config_word(o_config_word));
  prom_programmer u_prom_programmer (.i_ref_clk(i_ref_clk),
    .i_prog_done(o_prog_done), .i_prog_refused(o_prog_refused),
    .o_prog_valid(i_prog_valid), .o_prog_req(i_prog_req));
  // Clock at 4 ns
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic wrap_up();
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask : cyc
  task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask : reg_wr
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask : reg_rd
  task automatic prog(input prom_pkg::prog_cmd_e c, input logic [11:0] a,
                      input logic [15:0] d, input logic [1:0] e);
    u_prom_programmer.run(c, a, d);
    check("prog answer", {u_prom_programmer.got_done,
                          u_prom_programmer.got_ref}, e);
  endtask : prog
  // Cycles from the request cycle to the answer cycle
  task automatic fetch(output int k);
    @(posedge i_ref_clk);
    i_fetch_req <= 1'b1;
    @(posedge i_ref_clk);
    i_fetch_req <= 1'b0;
    k = 1;
    #1;
    while (o_fetch_valid !== 1'b1 && k < 20) begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end
  endtask : fetch
  // One-cycle CPU control: 0 jump, 1 interrupt, 2 return, 3 step
  task automatic pulse(input int w);
    @(posedge i_ref_clk);
    {i_pc_step, i_ret, i_irq_take, i_jump} <= 4'(1 << w);
    @(posedge i_ref_clk);
    {i_pc_step, i_ret, i_irq_take, i_jump} <= '0;
    cyc(2);
  endtask : pulse
  // Hang guard, far beyond the expected run length
  initial begin
    #80000;
    num_errors++;
    wrap_up();
  end
  initial begin
    {i_reset_n, i_por_n, i_reg_wr, i_reg_rd, i_fetch_req} = '0;
    {i_jump, i_irq_take, i_ret, i_pc_step, i_reg_addr, i_reg_wdata} = '0;
    i_jump_addr = '0;
    i_shared_pin = 1'b1;
    i_cpu_mode = prom_pkg::MODE_SLOW; // Slow run mode, so watchdog code 10 is on
    repeat (10) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    i_por_n <= 1'b1;
    cyc(3);
    check("pc", o_pc, 12'h000);
    check("cfg word", o_config_word, 16'h0200);
    check("cfg out", o_cfg, 8'h10);
    check("run", o_cpu_run, 1'b1);
    check("pin io", {o_ext_reset_req, o_pin_gpio_in}, 2'b01);
    reg_rd(9'h113, rd); check("delay", rd, 8'h00);
    reg_wr(9'h113, 8'hff); reg_rd(9'h113, rd); check("delay", rd, 8'h03);
    reg_wr(9'h1ff, 8'h55); reg_rd(9'h1ff, rd); check("cfg hi", rd, 8'h02);
    reg_rd(9'h0aa, rd); check("unmapped", rd, 8'h00);
    prog(prom_pkg::PROG_WRITE_CODE, 12'h000, 16'h1234, 2'b10);
    prog(prom_pkg::PROG_READ_CODE, 12'h000, 16'h0, 2'b10);
    check("code rd", o_prog_rdata, 16'h1234);
    // Every delay code, answer counted in cycles
    for (int d = 0; d < 4; d++) begin
      reg_wr(9'h113, 8'(d));
      fetch(n);
      check("fetch lat", n, lat[d]);
      check("fetch data", o_fetch_data, 16'h1234);
    end
    // Loop leaves the shortest delay in place for low supply
    reg_rd(9'h113, rd);
    check("delay 8ns", rd, 8'h03);
    // Lock set: code hidden and frozen, config still readable
    prog(prom_pkg::PROG_WRITE_INFO, 12'h000, 16'h8200, 2'b10);
    prog(prom_pkg::PROG_READ_CODE, 12'h000, 16'h0, 2'b01);
    check("locked rd", o_prog_rdata, 16'h0000);
    prog(prom_pkg::PROG_WRITE_CODE, 12'h000, 16'h5555, 2'b01);
    prog(prom_pkg::PROG_WRITE_INFO, 12'h000, 16'h0200, 2'b11);
    prog(prom_pkg::PROG_READ_INFO, 12'h000, 16'h0, 2'b10);
    check("info rd", o_prog_rdata, 16'h8200);
    prog(prom_pkg::PROG_ERASE_CODE, 12'h000, 16'h0, 2'b10);
    prog(prom_pkg::PROG_WRITE_INFO, 12'h000, 16'h2ab0, 2'b10);
    prog(prom_pkg::PROG_READ_CODE, 12'h000, 16'h0, 2'b10);
    check("erased", o_prog_rdata, 16'hffff);
    // Mid-run system reset relatches the stored word
    pulse(0);
    @(posedge i_ref_clk);
    i_reset_n <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    cyc(3);
    check("pc", o_pc, 12'h000);
    check("cfg word", o_config_word, 16'h2ab0);
    check("cfg out", o_cfg, 8'hd7);
    reg_rd(9'h1fe, rd); check("cfg lo", rd, 8'hb0);
    reg_rd(9'h113, rd); check("delay", rd, 8'h00);
    i_cpu_mode <= prom_pkg::MODE_IDLE;
    cyc(3);
    check("wdt idle", o_cfg.wdt_enable, 1'b0);
    i_shared_pin <= 1'b0;
    cyc(5);
    check("pin rst", {o_ext_reset_req, o_pin_gpio_in}, 2'b10);
    i_shared_pin <= 1'b1;
    prog(prom_pkg::PROG_WRITE_INFO, 12'h000, 16'h0000, 2'b10);
    check("cfg held", o_config_word, 16'h2ab0);
    check("pin rel", o_ext_reset_req, 1'b0);
    // Jump, interrupt entry and return
    i_jump_addr <= 12'h123;
    pulse(0);
    check("jump", o_pc, 12'h123);
    pulse(3);
    check("step", o_pc, 12'h124);
    pulse(1);
    check("irq", o_pc, 12'h004);
    pulse(2);
    check("ret", o_pc, 12'h124);
    wrap_up();
  end
endmodule : program_rom_and_config_word_bench
`default_nettype wire

/* sim/prom_programmer.sv */
// Behavioural device programmer driving the programming pins
`timescale 1ns/1ps
`default_nettype none
module prom_programmer (
  input wire logic i_ref_clk,
  input wire logic i_prog_done,
  input wire logic i_prog_refused,
  output logic o_prog_valid,
  output prom_pkg::prog_req_s o_prog_req
);
  logic busy = 1'b0;
  logic fire = 1'b0;
  logic got_done;
  logic got_ref;
  prom_pkg::prog_req_s want = '0;
  prom_pkg::prog_req_s idle_pat = '0;
  // Sole driver of the pins; idle request lines wander so no stale
  // command can be mistaken
  always @(posedge i_ref_clk) begin
    idle_pat <= ~idle_pat;
    o_prog_req <= busy ? want : idle_pat;
    o_prog_valid <= fire;
  end
  // One command: settle request, raise valid, wait bounded for answer
  task automatic run(input prom_pkg::prog_cmd_e c, input logic [11:0] a,
                     input logic [15:0] d);
    int n;
    busy = 1'b1;
    want = '{cmd: c, addr: a, wdata: d};
    repeat (2) @(posedge i_ref_clk);
    #1 fire = 1'b1;
    n = 0;
    got_done = 1'b0;
    got_ref = 1'b0;
    while (!(got_done | got_ref) && n < 30) begin
      @(posedge i_ref_clk);
      #1;
      got_done = i_prog_done;
      got_ref = i_prog_refused;
      n++;
    end
    fire = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1 busy = 1'b0;
  endtask : run
endmodule : prom_programmer
`default_nettype wire
